// ### address_breakpoint_unit.sv
/*
 * address breakpoint unit: pc compare, forced break, break state, wake flag,
 * timer halt, watchdog hold, axi4-lite register slave and masked interrupt.
 * assumes cpu_in comes from logic on the same clock; the test voltage sense
 * comes from a pin and is synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
module address_breakpoint_unit (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [brk_pkg::AXI_AW-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [brk_pkg::AXI_AW-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // cpu core
    input wire brk_pkg::cpu_bus_type cpu_in,
    output brk_pkg::brk_out_type brk_out,
    // reset pin test voltage sense
    input wire logic test_high_voltage,
    // interrupt
    output logic irq
);
    // ==========================================================
    // helpers
    function automatic logic reg_hit(input logic [brk_pkg::AXI_AW-1:0] a, input logic [15:0] idx);
        reg_hit = (a[brk_pkg::AXI_AW-1:2] == idx);
    endfunction

    function automatic logic any_hit(input logic [brk_pkg::AXI_AW-1:0] a);
        any_hit = reg_hit(a, brk_pkg::IDX_WAIT_STATUS) | reg_hit(a, brk_pkg::IDX_FLAG_CLEAR)
            | reg_hit(a, brk_pkg::IDX_ADDR_HIGH) | reg_hit(a, brk_pkg::IDX_ADDR_LOW)
            | reg_hit(a, brk_pkg::IDX_CTRL_STATUS) | reg_hit(a, brk_pkg::IDX_IRQ_STATUS)
            | reg_hit(a, brk_pkg::IDX_IRQ_MASK);
    endfunction

    // ==========================================================
    // state
    logic awready_ff, aw_held_ff, wready_ff, w_held_ff;
    logic [brk_pkg::AXI_AW-1:0] aw_addr_ff;
    logic [7:0] w_byte_ff;
    logic w_lane_ff;
    logic bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic match_enable_ff, active_flag_ff, exit_flag_ff, clear_enable_ff;
    logic [7:0] addr_high_ff, addr_low_ff;
    logic [brk_pkg::EV_W-1:0] ev_status_ff, ev_mask_ff;
    logic irq_ff;
    logic tst_meta_ff, tst_sync_ff;
    brk_pkg::brk_state_type state_ff, nxt_state;
    brk_pkg::brk_out_type out_ff, nxt_out;

    // ==========================================================
    // bus decode
    wire aw_take = awvalid & awready_ff;
    wire w_take = wvalid & wready_ff;
    wire ar_take = arvalid & arready_ff;
    wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire nxt_aw_held = aw_take | (aw_held_ff & ~wr_fire);
    wire nxt_w_held = w_take | (w_held_ff & ~wr_fire);
    wire wr_mapped = any_hit(aw_addr_ff);
    wire wr_go = wr_fire & w_lane_ff;
    wire wr_scr = wr_go & reg_hit(aw_addr_ff, brk_pkg::IDX_CTRL_STATUS);
    wire wr_wst = wr_go & reg_hit(aw_addr_ff, brk_pkg::IDX_WAIT_STATUS);
    wire wr_fcr = wr_go & reg_hit(aw_addr_ff, brk_pkg::IDX_FLAG_CLEAR);
    wire wr_hi = wr_go & reg_hit(aw_addr_ff, brk_pkg::IDX_ADDR_HIGH);
    wire wr_lo = wr_go & reg_hit(aw_addr_ff, brk_pkg::IDX_ADDR_LOW);
    wire wr_ist = wr_go & reg_hit(aw_addr_ff, brk_pkg::IDX_IRQ_STATUS);
    wire wr_msk = wr_go & reg_hit(aw_addr_ff, brk_pkg::IDX_IRQ_MASK);
    wire nxt_bvalid = wr_fire | (bvalid_ff & ~bready);
    wire nxt_rvalid = ar_take | (rvalid_ff & ~rready);

    // ==========================================================
    // read mux; unimplemented and reserved bits read zero
    wire [7:0] rd_scr = {match_enable_ff, active_flag_ff, 6'h00};
    wire [7:0] rd_wst = {6'h00, exit_flag_ff, 1'h0};
    wire [7:0] rd_fcr = {clear_enable_ff, 7'h00};
    wire [7:0] rd_byte =
        reg_hit(araddr, brk_pkg::IDX_CTRL_STATUS) ? rd_scr :
        reg_hit(araddr, brk_pkg::IDX_WAIT_STATUS) ? rd_wst :
        reg_hit(araddr, brk_pkg::IDX_FLAG_CLEAR) ? rd_fcr :
        reg_hit(araddr, brk_pkg::IDX_ADDR_HIGH) ? addr_high_ff :
        reg_hit(araddr, brk_pkg::IDX_ADDR_LOW) ? addr_low_ff :
        reg_hit(araddr, brk_pkg::IDX_IRQ_STATUS) ? {5'h00, ev_status_ff} :
        reg_hit(araddr, brk_pkg::IDX_IRQ_MASK) ? {5'h00, ev_mask_ff} : brk_pkg::BYTE_ZERO;
    wire [1:0] rd_resp = any_hit(araddr) ? brk_pkg::RESP_OKAY : brk_pkg::RESP_SLVERR;

    // ==========================================================
    // break events
    wire [15:0] break_addr = {addr_high_ff, addr_low_ff};
    // no wait-mode gating: the compare and forced break stay live in wait
    wire pc_match = match_enable_ff & cpu_in.pc_fetch & (cpu_in.addr == break_addr);
    wire force_break = wr_scr & w_byte_ff[brk_pkg::BIT_ACTIVE];
    wire in_break = (state_ff == brk_pkg::ST_BREAK);
    wire break_begin = ~in_break & (nxt_state == brk_pkg::ST_BREAK);
    wire leave_low_power = break_begin & (cpu_in.wait_mode | cpu_in.stop_mode);

    // sequencer: a match waits for the running instruction unless it is its last cycle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            brk_pkg::ST_IDLE: begin
                if (force_break | (pc_match & cpu_in.last_cycle)) begin
                    nxt_state = brk_pkg::ST_BREAK;
                end else if (pc_match) begin
                    nxt_state = brk_pkg::ST_PEND;
                end
            end
            brk_pkg::ST_PEND: begin
                if (cpu_in.instr_done | force_break) begin
                    nxt_state = brk_pkg::ST_BREAK;
                end
            end
            brk_pkg::ST_BREAK: begin
                if (cpu_in.return_from_interrupt) begin
                    nxt_state = brk_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = brk_pkg::ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // register next values; hardware set wins over a software clear
    wire nxt_active = pc_match | (wr_scr ? w_byte_ff[brk_pkg::BIT_ACTIVE] : active_flag_ff);
    wire exit_clear = wr_wst & ~w_byte_ff[brk_pkg::BIT_EXIT_FLAG];
    wire nxt_exit = leave_low_power | (exit_flag_ff & ~exit_clear);
    wire nxt_clear_enable = wr_fcr ? w_byte_ff[brk_pkg::BIT_CLEAR_ENABLE] : clear_enable_ff;
    wire [brk_pkg::EV_W-1:0] ev_set = {leave_low_power, force_break, pc_match};
    wire [brk_pkg::EV_W-1:0] ev_clr = wr_ist ? w_byte_ff[brk_pkg::EV_W-1:0] : brk_pkg::EV_ZERO;
    wire [brk_pkg::EV_W-1:0] nxt_status = ev_set | (ev_status_ff & ~ev_clr);
    wire [brk_pkg::EV_W-1:0] nxt_mask = wr_msk ? w_byte_ff[brk_pkg::EV_W-1:0] : ev_mask_ff;
    wire nxt_in_break = (nxt_state == brk_pkg::ST_BREAK);

    always_comb begin
        nxt_out = out_ff;
        nxt_out.break_request = break_begin;
        if (break_begin) begin
            nxt_out.break_vector = cpu_in.monitor_mode ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_NORMAL;
        end
        nxt_out.timer_halt = nxt_in_break;
        nxt_out.watchdog_disable = nxt_in_break & tst_sync_ff;
        nxt_out.clear_permit = ~nxt_in_break | nxt_clear_enable;
        nxt_out.wake_request = leave_low_power;
    end

    // ==========================================================
    // axi4-lite slave: address and data taken in either order
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awready_ff <= 1'h1;
            wready_ff <= 1'h1;
            aw_held_ff <= 1'h0;
            w_held_ff <= 1'h0;
            aw_addr_ff <= 18'h0_0000;
            w_byte_ff <= brk_pkg::BYTE_ZERO;
            w_lane_ff <= 1'h0;
            bvalid_ff <= 1'h0;
            bresp_ff <= brk_pkg::RESP_OKAY;
        end else if (clk_en) begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= ~nxt_aw_held;
            wready_ff <= ~nxt_w_held;
            if (aw_take) begin
                aw_addr_ff <= awaddr;
            end
            if (w_take) begin
                w_byte_ff <= wdata[7:0];
                w_lane_ff <= wstrb[0];
            end
            bvalid_ff <= nxt_bvalid;
            if (wr_fire) begin
                bresp_ff <= wr_mapped ? brk_pkg::RESP_OKAY : brk_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            arready_ff <= 1'h1;
            rvalid_ff <= 1'h0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= brk_pkg::RESP_OKAY;
        end else if (clk_en) begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= ~nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= {brk_pkg::PAD_ZERO, rd_byte};
                rresp_ff <= rd_resp;
            end
        end
    end

    // ==========================================================
    // break registers; reserved bits have no storage so writes vanish
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            match_enable_ff <= 1'h0;
            active_flag_ff <= 1'h0;
            exit_flag_ff <= 1'h0;
            clear_enable_ff <= 1'h0;
            addr_high_ff <= brk_pkg::BYTE_ZERO;
            addr_low_ff <= brk_pkg::BYTE_ZERO;
        end else if (clk_en) begin
            if (wr_scr) begin
                match_enable_ff <= w_byte_ff[brk_pkg::BIT_MATCH_ENABLE];
            end
            active_flag_ff <= nxt_active;
            exit_flag_ff <= nxt_exit;
            clear_enable_ff <= nxt_clear_enable;
            if (wr_hi) begin
                addr_high_ff <= w_byte_ff;
            end
            if (wr_lo) begin
                addr_low_ff <= w_byte_ff;
            end
        end
    end

    // interrupt status, mask and level output
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ev_status_ff <= brk_pkg::EV_ZERO;
            ev_mask_ff <= brk_pkg::EV_ZERO;
            irq_ff <= 1'h0;
        end else if (clk_en) begin
            ev_status_ff <= nxt_status;
            ev_mask_ff <= nxt_mask;
            irq_ff <= |(nxt_status & nxt_mask);
        end
    end

    // test voltage comes from a pin; two flops before use
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tst_meta_ff <= 1'h0;
            tst_sync_ff <= 1'h0;
        end else if (clk_en) begin
            tst_meta_ff <= test_high_voltage;
            tst_sync_ff <= tst_meta_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= brk_pkg::ST_IDLE;
            out_ff <= '{break_request: 1'h0, break_vector: brk_pkg::VEC_NORMAL, timer_halt: 1'h0,
                watchdog_disable: 1'h0, clear_permit: 1'h1, wake_request: 1'h0};
        end else if (clk_en) begin
            state_ff <= nxt_state;
            out_ff <= nxt_out;
        end
    end

    // ==========================================================
    // outputs
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign brk_out = out_ff;
    assign irq = irq_ff;

    // ==========================================================
    // assertions; a frozen clock enable cancels open attempts
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || !clk_en);

    sequence seq_break_start;
        brk_out.break_request && brk_out.timer_halt;
    endsequence

    sequence seq_held_break;
        brk_out.timer_halt [*2];
    endsequence

    a_match_waits_instr: assert property (
        (state_ff == brk_pkg::ST_IDLE) && pc_match && !cpu_in.last_cycle && !force_break
        |=> (state_ff == brk_pkg::ST_PEND) && !brk_out.break_request)
        else $error("match did not wait for instruction end");

    a_pend_then_break: assert property (
        (state_ff == brk_pkg::ST_PEND) && cpu_in.instr_done |=> seq_break_start)
        else $error("pending match did not start break");

    a_vector_select: assert property (
        break_begin |=> brk_out.break_vector ==
            ($past(cpu_in.monitor_mode) ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_NORMAL))
        else $error("wrong break vector");

    a_forced_break: assert property (
        !in_break && force_break |=> seq_break_start ##1 brk_out.timer_halt && !brk_out.break_request)
        else $error("forced break not taken");

    a_last_cycle_now: assert property (
        (state_ff == brk_pkg::ST_IDLE) && pc_match && cpu_in.last_cycle |=> seq_break_start)
        else $error("last cycle match did not break at once");

    a_rti_ends_break: assert property (
        in_break && cpu_in.return_from_interrupt |=> !brk_out.timer_halt && !brk_out.watchdog_disable)
        else $error("break not ended by return");

    a_clear_permit: assert property (
        brk_out.clear_permit == (!brk_out.timer_halt || clear_enable_ff))
        else $error("clear permit wrong");

    a_timer_halt_hold: assert property (
        in_break && !cpu_in.return_from_interrupt |=> brk_out.timer_halt)
        else $error("timers not halted in break");

    a_watchdog_hold: assert property (
        seq_held_break ##0 $past(tst_sync_ff) |-> brk_out.watchdog_disable)
        else $error("watchdog not held off");

    a_wake_sets_flag: assert property (
        leave_low_power |=> exit_flag_ff && brk_out.wake_request && ev_status_ff[brk_pkg::EV_WAKE])
        else $error("low power exit not flagged");

    a_exit_flag_clear: assert property (
        exit_clear && !leave_low_power |=> !exit_flag_ff)
        else $error("exit flag not cleared by zero");

    a_enable_gates: assert property (
        (state_ff == brk_pkg::ST_IDLE) && !match_enable_ff && !force_break |=> state_ff == brk_pkg::ST_IDLE)
        else $error("break without enable");

    a_active_on_match: assert property (
        pc_match |=> active_flag_ff && ev_status_ff[brk_pkg::EV_MATCH])
        else $error("active flag not set on match");

    a_irq_level: assert property (
        ##1 irq == |(ev_status_ff & ev_mask_ff))
        else $error("interrupt level mismatch");
endmodule // address_breakpoint_unit
`default_nettype wire

// ### brk_pkg.sv
/*
 * constants, register map, state and carrier types of the address breakpoint unit.
 * assumes an axi4-lite master with 32-bit data and a cpu core on the same clock.
 */
// How it works
// - enabled pc match on the address bus raises a break request.
// - break vector is fffc normally, fefc in monitor mode.
// - software writing one to the active flag forces a break.
// - match on an instruction's last cycle starts the break at once.
// - return from interrupt inside the break ends the break state.
// - outside flags clear during break only while clear-enable is set.
// - timers are halted while the break is active.
// - watchdog is held off in break while test voltage is present.
// - the unit keeps matching and forcing breaks in wait mode.
// - a break leaving stop mode sets the stop/wait exit flag.
// - exit flag resets to zero and clears when written with zero.
// - enable bit 7 gates the 16-bit compare, resets and writes to zero.
// - active flag sets on match, clears on reset or written zero.
// - a break leaving wait mode also sets the exit flag.
// - high and low address registers hold the break address, reset zero.
`default_nettype none
package brk_pkg;
    // ==========================================================
    // register indexes; byte address is four times the index
    localparam int AXI_AW = 18;
    localparam logic [15:0] IDX_WAIT_STATUS = 16'hfe00;
    localparam logic [15:0] IDX_FLAG_CLEAR = 16'hfe03;
    localparam logic [15:0] IDX_ADDR_HIGH = 16'hfe0c;
    localparam logic [15:0] IDX_ADDR_LOW = 16'hfe0d;
    localparam logic [15:0] IDX_CTRL_STATUS = 16'hfe0e;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hfe10;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hfe11;
    // ==========================================================
    // field positions
    localparam int BIT_MATCH_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_EXIT_FLAG = 1;
    localparam int BIT_CLEAR_ENABLE = 7;
    localparam int EV_MATCH = 0;
    localparam int EV_FORCE = 1;
    localparam int EV_WAKE = 2;
    localparam int EV_W = 3;
    // ==========================================================
    // reset values and fixed codes
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [EV_W-1:0] EV_ZERO = 3'h0;
    localparam logic [15:0] VEC_NORMAL = 16'hfffc;
    localparam logic [15:0] VEC_MONITOR = 16'hfefc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [23:0] PAD_ZERO = 24'h00_0000;
    // ==========================================================
    // break sequencer, gray along idle, pending, break
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_PEND = 2'h1,
        ST_BREAK = 2'h3
    } brk_state_type;
    // ==========================================================
    // cpu side carriers
    typedef struct packed {
        logic [15:0] addr;
        logic pc_fetch;
        logic last_cycle;
        logic instr_done;
        logic return_from_interrupt;
        logic wait_mode;
        logic stop_mode;
        logic monitor_mode;
    } cpu_bus_type;
    typedef struct packed {
        logic break_request;
        logic [15:0] break_vector;
        logic timer_halt;
        logic watchdog_disable;
        logic clear_permit;
        logic wake_request;
    } brk_out_type;
endpackage
`default_nettype wire

// ### cpu_model.sv
/*
 * cpu core stand-in: steps the program counter and drives the cpu bus of the breakpoint unit.
 * assumes brk_pkg is compiled first and that the bench shares one clock with the unit.
 */
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bench controls
    input wire logic run,
    input wire logic wait_in,
    input wire logic stop_in,
    input wire logic monitor_in,
    input wire logic routine_done,
    input wire logic [15:0] start_pc,
    // breakpoint unit
    input wire brk_pkg::brk_out_type brk_out,
    output var brk_pkg::cpu_bus_type cpu_in
);
    // ==========
    // program counter
    // even addresses take one cycle and odd ones two, so both match timings occur
    logic [15:0] pc_ff;
    logic second_ff;
    wire logic halted = !run || wait_in || stop_in || brk_out.timer_halt;
    wire logic last_w = !halted && (second_ff || !pc_ff[0]);
    wire logic fetch_w = !halted && !second_ff;
    // the break routine ends only when the bench says software is done with it
    wire logic rti_w = brk_out.timer_halt && routine_done;
    always_ff @(posedge clock) begin
        if (!rst_n || !run) begin
            pc_ff <= start_pc;
            second_ff <= 1'b0;
        end else if (!halted) begin
            second_ff <= pc_ff[0] && !second_ff;
            if (!pc_ff[0] || second_ff) begin
                pc_ff <= pc_ff + 16'h0001;
            end
        end
    end
    assign cpu_in = '{pc_ff, fetch_w, last_w, last_w, rti_w, wait_in, stop_in, monitor_in};
endmodule // cpu_model
`default_nettype wire

// ### testbench.sv
/*
 * self-checking bench of the address breakpoint unit: register bus, matches, forced breaks, wake.
 * assumes brk_pkg, the unit and cpu_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ==========
    // signals
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [brk_pkg::AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic test_high_voltage = 1'b0, run = 1'b0, wait_in = 1'b0, stop_in = 1'b0;
    logic monitor_in = 1'b0, routine_done = 1'b0;
    logic [15:0] start_pc = 16'h0000, bp = 16'h0000;
    brk_pkg::cpu_bus_type cpu_in;
    brk_pkg::brk_out_type brk_out;
    int mismatches = 0, n_tests = 0, cycle = 0, fetch_cyc = 0;
    always #2 clock = ~clock;
    always @(posedge clock) cycle <= cycle + 1;
    always @(posedge clock) if (cpu_in.pc_fetch === 1'b1 && cpu_in.addr === bp) fetch_cyc <= cycle;
    address_breakpoint_unit dut (
        .clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .cpu_in(cpu_in), .brk_out(brk_out),
        .test_high_voltage(test_high_voltage), .irq(irq));
    cpu_model cpu (
        .clock(clock), .rst_n(rst_n), .run(run), .wait_in(wait_in), .stop_in(stop_in),
        .monitor_in(monitor_in), .routine_done(routine_done), .start_pc(start_pc),
        .brk_out(brk_out), .cpu_in(cpu_in));
    // ==========
    // shared tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge clock);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check("bresp", {14'h0, er}, {14'h0, bresp});
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'h0);
        @(posedge clock);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        check("rdata", {8'h00, exp}, rdata[15:0]);
        check("rresp", {14'h0, er}, {14'h0, rresp});
        rready <= 1'b0;
    endtask
    task automatic wait_brk(input logic [15:0] vec);
        int n = 0;
        while (brk_out.break_request !== 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
        end
        check("break request", 16'h0001, {15'h0000, brk_out.break_request});
        check("timer halt", 16'h0001, {15'h0000, brk_out.timer_halt});
        check("vector", vec, brk_out.break_vector);
    endtask
    // software clears the active flag, then returns from the routine
    task automatic end_brk(input logic [7:0] ctrl);
        wr(brk_pkg::IDX_CTRL_STATUS, ctrl);
        rd(brk_pkg::IDX_CTRL_STATUS, ctrl);
        check("halt held", 16'h0001, {15'h0000, brk_out.timer_halt});
        routine_done <= 1'b1;
        run <= 1'b0;
        repeat (3) @(posedge clock);
        check("halt after return", 16'h0000, {15'h0000, brk_out.timer_halt});
        routine_done <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        logic [15:0] regs [5];
        regs = '{brk_pkg::IDX_WAIT_STATUS, brk_pkg::IDX_FLAG_CLEAR, brk_pkg::IDX_ADDR_HIGH,
            brk_pkg::IDX_ADDR_LOW, brk_pkg::IDX_CTRL_STATUS};
        foreach (regs[i]) rd(regs[i], 8'h00);
        check("clear permit", 16'h0001, {15'h0000, brk_out.clear_permit});
        $display("test reset done");
    endtask
    task automatic t_regs;
        wr(brk_pkg::IDX_CTRL_STATUS, 8'h3f);
        rd(brk_pkg::IDX_CTRL_STATUS, 8'h00);
        wr(brk_pkg::IDX_FLAG_CLEAR, 8'h80);
        rd(brk_pkg::IDX_FLAG_CLEAR, 8'h80);
        wr(brk_pkg::IDX_FLAG_CLEAR, 8'h00);
        rd(brk_pkg::IDX_FLAG_CLEAR, 8'h00);
        wr(16'hfe01, 8'hff, brk_pkg::RESP_SLVERR);
        rd(16'hfe01, 8'h00, brk_pkg::RESP_SLVERR);
        $display("test registers done");
    endtask
    task automatic t_match_last;
        // the cpu stand-in reloads its pc only while stopped, so set it before run rises
        start_pc <= 16'h1230;
        bp <= 16'h1234;
        wr(brk_pkg::IDX_ADDR_HIGH, 8'h12);
        wr(brk_pkg::IDX_ADDR_LOW, 8'h34);
        rd(brk_pkg::IDX_ADDR_HIGH, 8'h12);
        rd(brk_pkg::IDX_ADDR_LOW, 8'h34);
        wr(brk_pkg::IDX_IRQ_MASK, 8'h01);
        wr(brk_pkg::IDX_CTRL_STATUS, 8'h80);
        run <= 1'b1;
        wait_brk(brk_pkg::VEC_NORMAL);
        check("match delay", 16'h0001, 16'(cycle - fetch_cyc));
        rd(brk_pkg::IDX_CTRL_STATUS, 8'hc0);
        check("irq raised", 16'h0001, {15'h0000, irq});
        check("clear permit", 16'h0000, {15'h0000, brk_out.clear_permit});
        test_high_voltage <= 1'b1;
        wr(brk_pkg::IDX_FLAG_CLEAR, 8'h80);
        wr(brk_pkg::IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge clock);
        check("clear permit", 16'h0001, {15'h0000, brk_out.clear_permit});
        check("watchdog off", 16'h0001, {15'h0000, brk_out.watchdog_disable});
        check("irq cleared", 16'h0000, {15'h0000, irq});
        end_brk(8'h80);
        @(posedge clock);
        check("watchdog back", 16'h0000, {15'h0000, brk_out.watchdog_disable});
        test_high_voltage <= 1'b0;
        $display("test match on last cycle done");
    endtask
    task automatic t_match_pending;
        start_pc <= 16'h1ffe;
        bp <= 16'h2001;
        wr(brk_pkg::IDX_ADDR_HIGH, 8'h20);
        wr(brk_pkg::IDX_ADDR_LOW, 8'h01);
        wr(brk_pkg::IDX_CTRL_STATUS, 8'h00);
        run <= 1'b1;
        repeat (20) @(posedge clock);
        check("no break when off", 16'h0000, {15'h0000, brk_out.timer_halt});
        run <= 1'b0;
        wr(brk_pkg::IDX_CTRL_STATUS, 8'h80);
        run <= 1'b1;
        wait_brk(brk_pkg::VEC_NORMAL);
        check("pending delay", 16'h0002, 16'(cycle - fetch_cyc));
        end_brk(8'h00);
        $display("test pending match done");
    endtask
    task automatic t_force_monitor;
        monitor_in <= 1'b1;
        // the pending match left its status bit set; clear it so only the forced event remains
        wr(brk_pkg::IDX_IRQ_STATUS, 8'h07);
        wr(brk_pkg::IDX_CTRL_STATUS, 8'h40);
        wait_brk(brk_pkg::VEC_MONITOR);
        check("irq masked", 16'h0000, {15'h0000, irq});
        rd(brk_pkg::IDX_IRQ_STATUS, 8'h02);
        end_brk(8'h00);
        monitor_in <= 1'b0;
        $display("test forced break done");
    endtask
    task automatic t_wait_stop;
        for (int i = 0; i < 2; i++) begin
            wait_in <= (i == 0);
            stop_in <= (i == 1);
            wr(brk_pkg::IDX_CTRL_STATUS, 8'h40);
            wait_brk(brk_pkg::VEC_NORMAL);
            check("wake", 16'h0001, {15'h0000, brk_out.wake_request});
            rd(brk_pkg::IDX_WAIT_STATUS, 8'h02);
            wr(brk_pkg::IDX_WAIT_STATUS, 8'h02);
            rd(brk_pkg::IDX_WAIT_STATUS, 8'h02);
            wr(brk_pkg::IDX_WAIT_STATUS, 8'h00);
            rd(brk_pkg::IDX_WAIT_STATUS, 8'h00);
            end_brk(8'h00);
        end
        wait_in <= 1'b0;
        stop_in <= 1'b0;
        $display("test wait and stop done");
    endtask
    // ==========
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_regs;
        t_match_last;
        t_match_pending;
        t_force_monitor;
        t_wait_stop;
        stop_test;
    end
    initial begin
        #80000;
        mismatches++;
        stop_test;
    end
endmodule // testbench
`default_nettype wire
